// File: design/dis_start_logic.sv
// Functional notes
// - Factory inputs: fwd, rev, speeds, ack, lock
// - Inputs 3 and 4 together give 20 Hz
// - Functions act on high level; shareable inputs
// - Scheme 3: input fwd/rev level starts
// - Scheme 3: fwd and rev interlocked
// - Scheme 0 like 3 plus restart
// - Auto restart needs setting 1, no edge
// - Scheme 1: run plus reverse select
// - Scheme 2: start pulse, stop pulse
// - Forward selector 0 off, 1-6 inputs
// - Reverse selector uses same encoding
// - Reverse function forces reverse direction while active
// - External fault raised while input high
`default_nettype none
module dis_start_logic (
    input  wire logic        pclk,            // APB clock, 50 MHz
    input  wire logic        presetn,         // Async reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error, unmapped
    input  wire logic        digital_input_1, // 24 V input 1
    input  wire logic        digital_input_2, // 24 V input 2
    input  wire logic        digital_input_3, // 24 V input 3
    input  wire logic        digital_input_4, // 24 V input 4
    input  wire logic        digital_input_5, // 24 V input 5
    input  wire logic        digital_input_6, // 24 V input 6
    output logic             run_cmd,         // Motor run command
    output logic             reverse_dir,     // Reverse rotation
    output logic             motor_fault,     // Fault state
    output logic             regulator_lock,  // Process regulator locked
    output logic      [7:0]  preset_speed_hz, // Preset speed, 0 = none
    output logic             irq              // Level interrupt
);
    import dis_pkg::*;

    dis_regs_t   regs_reg;
    dis_regs_t   regs_next;
    logic [5:0]  din;
    logic [5:0]  rise;
    logic        forward_run;
    logic        reverse_run;
    logic        fwd_r;
    logic        rev_r;
    logic        flip;
    logic        xf;
    logic        ack;
    logic        auto_ok;
    logic        cmd;
    logic        base_rev;
    logic        go;
    logic        acc;
    logic        wr_do;
    logic [2:0]  ev;

    function automatic logic pick(input logic [7:0] sel, input logic [5:0] v);
        logic res;
        res = 1'b0;
        if (sel != 8'h00 && sel <= DIS_SEL_MAX) begin
            res = v[3'(sel - 8'h01)];
        end
        return res;
    endfunction

    assign din = {digital_input_6, digital_input_5, digital_input_4,
                  digital_input_3, digital_input_2, digital_input_1};

    always_comb begin
        regs_next = regs_reg;
        // Second stage feeds all decoding; first stage stays private
        regs_next.s1 = din;
        regs_next.s2 = regs_reg.s1;
        regs_next.s3 = regs_reg.s2;
        rise = regs_reg.s2 & ~regs_reg.s3;
        // One input may feed several selectors at once
        forward_run   = pick(regs_reg.fsel, regs_reg.s2);
        reverse_run   = pick(regs_reg.rsel, regs_reg.s2);
        fwd_r = pick(regs_reg.fsel, rise);
        rev_r = pick(regs_reg.rsel, rise);
        flip  = pick(regs_reg.dsel, regs_reg.s2);
        xf    = pick(regs_reg.xsel, regs_reg.s2);
        ack   = rise[DIS_DI_ACK];
        auto_ok = (regs_reg.scheme == DIS_SCH_AUTO) &&
                  (regs_reg.auto == DIS_AUTO_ON);

        // Pulse latch: stop wins over start; held clear outside scheme 2
        // so a stale start cannot fire when the scheme is switched to 2
        if (rev_r || xf || regs_reg.scheme != DIS_SCH_PULSE) begin
            regs_next.pulse_run = 1'b0;
        end else if (fwd_r) begin
            regs_next.pulse_run = 1'b1;
        end

        cmd = 1'b0;
        base_rev = 1'b0;
        case (regs_reg.scheme)
            DIS_SCH_AUTO, DIS_SCH_XOR: begin
                cmd = forward_run ^ reverse_run;
                base_rev = reverse_run & ~forward_run;
            end
            DIS_SCH_DIR: begin
                cmd = forward_run;
                base_rev = reverse_run;
            end
            DIS_SCH_PULSE: begin
                cmd = regs_reg.pulse_run;
            end
            default: begin
                cmd = 1'b0;
            end
        endcase

        // After a fault a held level must not restart the motor by itself unless auto restart is on
        regs_next.wait_edge = (regs_reg.wait_edge & ~(fwd_r | rev_r)) | xf;
        go = cmd & ~(regs_reg.wait_edge & ~auto_ok);

        case (regs_reg.state)
            DIS_STOP: begin
                if (go) begin
                    regs_next.state = DIS_RUN;
                end
            end
            DIS_RUN: begin
                if (!cmd) begin
                    regs_next.state = DIS_STOP;
                end
            end
            DIS_FAULT: begin
                if (ack && !xf) begin
                    regs_next.state = DIS_STOP;
                end
            end
            default: begin
                regs_next.state = DIS_STOP;
            end
        endcase
        if (xf) begin
            regs_next.state = DIS_FAULT;
        end

        regs_next.run   = (regs_next.state == DIS_RUN);
        regs_next.fault = (regs_next.state == DIS_FAULT);
        regs_next.reverse_run   = base_rev | flip;
        regs_next.lock  = regs_reg.s2[DIS_DI_LOCK];
        case ({regs_reg.s2[DIS_DI_FF2], regs_reg.s2[DIS_DI_FF1]})
            2'b01: regs_next.speed = DIS_FF1_HZ;
            2'b10: regs_next.speed = DIS_FF2_HZ;
            2'b11: regs_next.speed = DIS_FF3_HZ;
            default: regs_next.speed = 8'h00;
        endcase

        ev = 3'b000;
        ev[DIS_IRQ_FAULT] = regs_next.fault & ~regs_reg.fault;
        ev[DIS_IRQ_START] = regs_next.run & ~regs_reg.run;
        ev[DIS_IRQ_STOP]  = regs_reg.run & (regs_next.state == DIS_STOP);

        // APB: one wait state, answer registered
        acc   = psel & penable;
        wr_do = acc & regs_reg.pready & pwrite & ~regs_reg.slverr;
        regs_next.pready = acc & ~regs_reg.pready;
        regs_next.slverr = 1'b0;
        if (acc && !regs_reg.pready) begin
            regs_next.prdata = 32'h0000_0000;
            if (paddr == DIS_OFF_SCHEME) begin
                regs_next.prdata[7:0] = regs_reg.scheme;
            end else if (paddr == DIS_OFF_FWD_SEL) begin
                regs_next.prdata[7:0] = regs_reg.fsel;
            end else if (paddr == DIS_OFF_REV_SEL) begin
                regs_next.prdata[7:0] = regs_reg.rsel;
            end else if (paddr == DIS_OFF_DIR_SEL) begin
                regs_next.prdata[7:0] = regs_reg.dsel;
            end else if (paddr == DIS_OFF_XF_SEL) begin
                regs_next.prdata[7:0] = regs_reg.xsel;
            end else if (paddr == DIS_OFF_AUTO) begin
                regs_next.prdata[7:0] = regs_reg.auto;
            end else if (paddr == DIS_OFF_STATUS) begin
                regs_next.prdata[4:0] = {regs_reg.wait_edge, regs_reg.lock,
                                         regs_reg.fault, regs_reg.reverse_run,
                                         regs_reg.run};
            end else if (paddr == DIS_OFF_IRQ_ST) begin
                regs_next.prdata[2:0] = regs_reg.irq_st;
            end else if (paddr == DIS_OFF_IRQ_MASK) begin
                regs_next.prdata[2:0] = regs_reg.irq_mask;
            end else begin
                regs_next.slverr = 1'b1;
            end
        end

        // Hardware set wins over a same-cycle write-one clear
        regs_next.irq_st = regs_reg.irq_st | ev;
        if (wr_do) begin
            if (paddr == DIS_OFF_SCHEME) begin
                regs_next.scheme = pwdata[7:0];
            end else if (paddr == DIS_OFF_FWD_SEL) begin
                regs_next.fsel = pwdata[7:0];
            end else if (paddr == DIS_OFF_REV_SEL) begin
                regs_next.rsel = pwdata[7:0];
            end else if (paddr == DIS_OFF_DIR_SEL) begin
                regs_next.dsel = pwdata[7:0];
            end else if (paddr == DIS_OFF_XF_SEL) begin
                regs_next.xsel = pwdata[7:0];
            end else if (paddr == DIS_OFF_AUTO) begin
                regs_next.auto = pwdata[7:0];
            end else if (paddr == DIS_OFF_IRQ_ST) begin
                regs_next.irq_st = (regs_reg.irq_st & ~pwdata[2:0]) | ev;
            end else if (paddr == DIS_OFF_IRQ_MASK) begin
                regs_next.irq_mask = pwdata[2:0];
            end
        end
        regs_next.irq = |(regs_next.irq_st & regs_next.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_reg <= DIS_REGS_RST;
        end else begin
            regs_reg <= regs_next;
        end
    end

    assign prdata          = regs_reg.prdata;
    assign pready          = regs_reg.pready;
    assign pslverr         = regs_reg.slverr;
    assign run_cmd         = regs_reg.run;
    assign reverse_dir     = regs_reg.reverse_run;
    assign motor_fault     = regs_reg.fault;
    assign regulator_lock  = regs_reg.lock;
    assign preset_speed_hz = regs_reg.speed;
    assign irq             = regs_reg.irq;

    default clocking dis_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    lock_follow_a: assert property (
        ##3 regulator_lock == $past(digital_input_6, 3))
        else $error("regulator lock does not follow input 6");

    speed_three_a: assert property (
        digital_input_3 && digital_input_4 ##3 1'b1 |->
        preset_speed_hz == DIS_FF3_HZ)
        else $error("preset speed 3 not selected");

    xor_block_a: assert property (
        regs_reg.scheme == DIS_SCH_XOR && forward_run && reverse_run && !xf |=> !run_cmd)
        else $error("run with both start inputs");

    fault_raise_a: assert property (
        xf |=> motor_fault && !run_cmd)
        else $error("external fault not raised");

    pulse_stop_a: assert property (
        regs_reg.scheme == DIS_SCH_PULSE && rev_r |-> ##2 !run_cmd)
        else $error("stop pulse ignored");

    flip_dir_a: assert property (
        flip |=> reverse_dir)
        else $error("reverse function ignored");

    auto_restart_a: assert property (
        regs_reg.state == DIS_STOP && auto_ok && regs_reg.wait_edge &&
        cmd && !xf |=> run_cmd)
        else $error("auto restart not taken");

    edge_wait_a: assert property (
        regs_reg.state == DIS_STOP && regs_reg.scheme == DIS_SCH_XOR &&
        regs_reg.wait_edge && !fwd_r && !rev_r |=> !run_cmd)
        else $error("restart without fresh edge");

    dir_mode_a: assert property (
        regs_reg.scheme == DIS_SCH_DIR && reverse_run |=> reverse_dir)
        else $error("direction input ignored");

    sel_off_a: assert property (
        regs_reg.fsel == 8'h00 |-> !forward_run && !fwd_r)
        else $error("deactivated selector drives start");

    // Fixed inputs: speeds and lock follow three edges later
    speed_one_a: assert property (
        digital_input_3 && !digital_input_4 ##3 1'b1 |-> preset_speed_hz == DIS_FF1_HZ)
        else $error("preset speed 1 not selected");

    speed_two_a: assert property (
        !digital_input_3 && digital_input_4 ##3 1'b1 |-> preset_speed_hz == DIS_FF2_HZ)
        else $error("preset speed 2 not selected");

    speed_none_a: assert property (
        !digital_input_3 && !digital_input_4 ##3 1'b1 |-> preset_speed_hz == 8'h00)
        else $error("preset speed without input");

    share_input_a: assert property (
        regs_reg.fsel == regs_reg.dsel && forward_run |-> flip)
        else $error("shared input drives one function only");

    xor_fwd_a: assert property (
        regs_reg.scheme == DIS_SCH_XOR && forward_run && !reverse_run && !xf && !flip &&
        !regs_reg.wait_edge && regs_reg.state != DIS_FAULT |=> run_cmd && !reverse_dir)
        else $error("forward start not taken");

    xor_rev_a: assert property (
        regs_reg.scheme == DIS_SCH_XOR && reverse_run && !forward_run && !xf &&
        !regs_reg.wait_edge && regs_reg.state != DIS_FAULT |=> run_cmd && reverse_dir)
        else $error("reverse start not taken");

    xor_idle_a: assert property (
        regs_reg.scheme == DIS_SCH_XOR && !forward_run && !reverse_run |=> !run_cmd)
        else $error("run without start input");

    auto_idle_a: assert property (
        regs_reg.scheme == DIS_SCH_AUTO && forward_run == reverse_run |=> !run_cmd)
        else $error("scheme 0 interlock broken");

    auto_fwd_a: assert property (
        regs_reg.scheme == DIS_SCH_AUTO && forward_run && !reverse_run && !xf && !flip &&
        !regs_reg.wait_edge && regs_reg.state != DIS_FAULT |=> run_cmd && !reverse_dir)
        else $error("scheme 0 forward start not taken");

    no_auto_a: assert property (
        regs_reg.state == DIS_STOP && regs_reg.scheme == DIS_SCH_AUTO &&
        regs_reg.auto != DIS_AUTO_ON && regs_reg.wait_edge && !fwd_r && !rev_r |=> !run_cmd)
        else $error("restart without auto setting");

    dir_fwd_a: assert property (
        regs_reg.scheme == DIS_SCH_DIR && !reverse_run && !flip |=> !reverse_dir)
        else $error("reverse without direction input");

    dir_run_a: assert property (
        regs_reg.scheme == DIS_SCH_DIR && !forward_run |=> !run_cmd)
        else $error("run without run input");

    pulse_start_a: assert property (
        regs_reg.scheme == DIS_SCH_PULSE && fwd_r && !rev_r && !xf &&
        regs_reg.state != DIS_FAULT |-> ##2 run_cmd)
        else $error("start pulse ignored");

    pulse_hold_a: assert property (
        regs_reg.scheme == DIS_SCH_PULSE && !fwd_r && !rev_r && !xf |=>
        $stable(regs_reg.pulse_run))
        else $error("pulse latch moved without pulse");

    sel_high_a: assert property (
        regs_reg.fsel > DIS_SEL_MAX |-> !forward_run && !fwd_r)
        else $error("out of range selector drives start");

    sel_map_a: assert property (
        regs_reg.fsel == DIS_RST_FWD_SEL |-> forward_run == regs_reg.s2[0])
        else $error("forward selector 1 not input 1");

    rev_off_a: assert property (
        regs_reg.rsel == 8'h00 || regs_reg.rsel > DIS_SEL_MAX |-> !reverse_run && !rev_r)
        else $error("unused reverse selector drives start");

    rev_map_a: assert property (
        regs_reg.rsel == DIS_RST_REV_SEL |-> reverse_run == regs_reg.s2[1])
        else $error("reverse selector 2 not input 2");

    flip_off_a: assert property (
        regs_reg.dsel == 8'h00 && regs_reg.scheme == DIS_SCH_XOR && !reverse_run |=> !reverse_dir)
        else $error("reverse with function unassigned");

    fault_hold_a: assert property (
        regs_reg.state == DIS_FAULT && !ack |=> motor_fault)
        else $error("fault left without acknowledge");

    fault_flag_a: assert property (
        $rose(motor_fault) |-> regs_reg.irq_st[DIS_IRQ_FAULT])
        else $error("fault event not flagged");

    // Decoding sees inputs exactly two edges old
    sync_stage_a: assert property (
        regs_reg.s2 == $past(din, 2))
        else $error("input synchroniser depth wrong");

    fwd_start_c: cover property (
        regs_reg.scheme == DIS_SCH_XOR ##1 run_cmd && !reverse_dir);
    pulse_run_c: cover property (
        regs_reg.scheme == DIS_SCH_PULSE && fwd_r ##2 run_cmd);
    fault_ack_c: cover property (
        motor_fault ##[1:20] !motor_fault);
    auto_restart_c: cover property (
        auto_ok && regs_reg.wait_edge ##1 run_cmd);
    dir_rev_c: cover property (
        regs_reg.scheme == DIS_SCH_DIR ##1 run_cmd && reverse_dir);
endmodule
`default_nettype wire

// File: shared/dis_pkg.sv
`default_nettype none
package dis_pkg;
    // Register byte offsets
    localparam logic [7:0] DIS_OFF_SCHEME   = 8'h00;
    localparam logic [7:0] DIS_OFF_FWD_SEL  = 8'h04;
    localparam logic [7:0] DIS_OFF_REV_SEL  = 8'h08;
    localparam logic [7:0] DIS_OFF_DIR_SEL  = 8'h0c;
    localparam logic [7:0] DIS_OFF_XF_SEL   = 8'h10;
    localparam logic [7:0] DIS_OFF_AUTO     = 8'h14;
    localparam logic [7:0] DIS_OFF_STATUS   = 8'h18;
    localparam logic [7:0] DIS_OFF_IRQ_ST   = 8'h1c;
    localparam logic [7:0] DIS_OFF_IRQ_MASK = 8'h20;
    // Reset values
    localparam logic [7:0] DIS_RST_SCHEME   = 8'h03;
    localparam logic [7:0] DIS_RST_FWD_SEL  = 8'h01;
    localparam logic [7:0] DIS_RST_REV_SEL  = 8'h02;
    localparam logic [7:0] DIS_RST_DIR_SEL  = 8'h00;
    localparam logic [7:0] DIS_RST_XF_SEL   = 8'h00;
    localparam logic [7:0] DIS_RST_AUTO     = 8'h00;
    // Start/stop schemes and selector range
    localparam logic [7:0] DIS_SCH_AUTO     = 8'h00;
    localparam logic [7:0] DIS_SCH_DIR      = 8'h01;
    localparam logic [7:0] DIS_SCH_PULSE    = 8'h02;
    localparam logic [7:0] DIS_SCH_XOR      = 8'h03;
    localparam logic [7:0] DIS_AUTO_ON      = 8'h01;
    localparam logic [7:0] DIS_SEL_MAX      = 8'h06;
    // Preset speeds in Hz
    localparam logic [7:0] DIS_FF1_HZ       = 8'h0a;
    localparam logic [7:0] DIS_FF2_HZ       = 8'h0f;
    localparam logic [7:0] DIS_FF3_HZ       = 8'h14;
    // Fixed input positions (0 = input 1)
    localparam int DIS_DI_FF1  = 2;
    localparam int DIS_DI_FF2  = 3;
    localparam int DIS_DI_ACK  = 4;
    localparam int DIS_DI_LOCK = 5;
    // Interrupt bits
    localparam int DIS_IRQ_FAULT = 0;
    localparam int DIS_IRQ_START = 1;
    localparam int DIS_IRQ_STOP  = 2;

    typedef enum logic [2:0] {
        DIS_STOP  = 3'b001,
        DIS_RUN   = 3'b010,
        DIS_FAULT = 3'b100
    } dis_state_t;

    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  s3;
        logic [7:0]  scheme;
        logic [7:0]  fsel;
        logic [7:0]  rsel;
        logic [7:0]  dsel;
        logic [7:0]  xsel;
        logic [7:0]  auto;
        dis_state_t  state;
        logic        pulse_run;
        logic        wait_edge;
        logic        run;
        logic        reverse_run;
        logic        fault;
        logic        lock;
        logic [7:0]  speed;
        logic [2:0]  irq_st;
        logic [2:0]  irq_mask;
        logic        irq;
        logic        pready;
        logic        slverr;
        logic [31:0] prdata;
    } dis_regs_t;

    localparam dis_regs_t DIS_REGS_RST = '{
        scheme: DIS_RST_SCHEME, fsel: DIS_RST_FWD_SEL,
        rsel: DIS_RST_REV_SEL, dsel: DIS_RST_DIR_SEL,
        xsel: DIS_RST_XF_SEL, auto: DIS_RST_AUTO,
        state: DIS_STOP, default: '0};
endpackage
`default_nettype wire

// File: bench/dis_switch_model.sv
`default_nettype none
module dis_switch_model (
    input  wire logic       pclk, // Bench clock
    input  wire logic [5:0] lvl,  // Held switch levels
    input  wire logic [5:0] pls,  // One-cycle pulse request
    output logic      [5:0] di    // Drive to inputs 1..6
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] pls_reg;
    // Pulse stretched to two cycles so one clean edge is seen
    always_ff @(posedge pclk) begin
        pls_reg <= pls;
        di      <= lvl | pls | pls_reg;
    end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dis_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [5:0]  lvl     = 6'h00;
    logic [5:0]  pls     = 6'h00;
    logic [31:0] prdata, q, seed;
    logic        pready, pslverr, e, run_cmd, reverse_dir, motor_fault, regulator_lock, irq;
    logic [7:0]  preset_speed_hz;
    logic [5:0]  di, v;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    logic [7:0]  rst_tab [6] = '{8'h03, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00};

    dis_start_logic DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .digital_input_1(di[0]), .digital_input_2(di[1]),
        .digital_input_3(di[2]), .digital_input_4(di[3]), .digital_input_5(di[4]),
        .digital_input_6(di[5]), .run_cmd(run_cmd), .reverse_dir(reverse_dir),
        .motor_fault(motor_fault), .regulator_lock(regulator_lock),
        .preset_speed_hz(preset_speed_hz), .irq(irq));
    dis_switch_model SW (.pclk(pclk), .lvl(lvl), .pls(pls), .di(di));

    always #10 pclk = ~pclk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] exp_speed(input logic [5:0] x);
        case ({x[DIS_DI_FF2], x[DIS_DI_FF1]})
            2'b01: return DIS_FF1_HZ;
            2'b10: return DIS_FF2_HZ;
            2'b11: return DIS_FF3_HZ;
            default: return 8'h00;
        endcase
    endfunction

    // Entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic set_in(input logic [5:0] x);
        lvl <= x;
        repeat (6) @(posedge pclk);
    endtask

    task automatic pulse(input logic [5:0] m);
        pls <= m;
        @(posedge pclk);
        pls <= 6'h00;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        seed = 32'hfbd7;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_val("reset value", 32'(rst_tab[i]), q);
            seed = lfsr(seed);
            apb(1'b1, 8'(4 * i), seed);
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_val("readback", 32'(seed[7:0]), q);
            apb(1'b1, 8'(4 * i), 32'(rst_tab[i]));
        end
        apb(1'b0, 8'h24, 32'h0);
        chk_bit("unmapped err", 1'b1, e);
        // Corner levels first, then random ones; ack input kept low
        for (int i = 0; i < 45; i++) begin
            seed = lfsr(seed);
            v = (i < 5) ? 6'({6'h20, 6'h0c, 6'h03, 6'h02, 6'h01} >> (6 * i)) : seed[5:0] & 6'h2f;
            set_in(v);
            chk_bit("run", v[0] ^ v[1], run_cmd);
            if (v[0] ^ v[1]) chk_bit("dir", v[1], reverse_dir);
            chk_val("speed", 32'(exp_speed(v)), 32'(preset_speed_hz));
            chk_bit("lock", v[DIS_DI_LOCK], regulator_lock);
        end
        for (int k = 0; k < 16; k++) begin
            set_in(6'h00);
            apb(1'b1, k[0] ? DIS_OFF_REV_SEL : DIS_OFF_FWD_SEL, 32'(k >> 1));
            apb(1'b1, k[0] ? DIS_OFF_FWD_SEL : DIS_OFF_REV_SEL, 32'h0);
            set_in((k >> 1) inside {[1:6]} ? 6'(1 << ((k >> 1) - 1)) : 6'h3f);
            chk_bit("sel run", (k >> 1) inside {[1:6]}, run_cmd);
            if ((k >> 1) inside {[1:6]}) chk_bit("sel dir", k[0], reverse_dir);
        end
        apb(1'b1, DIS_OFF_FWD_SEL, 32'h1);
        apb(1'b1, DIS_OFF_REV_SEL, 32'h2);
        for (int j = 0; j < 3; j++) begin
            set_in(6'h00);
            apb(1'b1, DIS_OFF_DIR_SEL, (j == 0) ? 32'h1 : 32'h3);
            set_in((j == 1) ? 6'h05 : 6'h01);
            chk_bit("flip", j < 2, reverse_dir);
        end
        apb(1'b1, DIS_OFF_DIR_SEL, 32'h0);
        apb(1'b1, DIS_OFF_XF_SEL, 32'h4);
        for (int j = 0; j < 3; j++) begin
            set_in(6'h00);
            apb(1'b1, DIS_OFF_SCHEME, (j == 0) ? 32'h3 : 32'h0);
            apb(1'b1, DIS_OFF_AUTO, (j == 1) ? 32'h1 : 32'h0);
            apb(1'b1, DIS_OFF_IRQ_MASK, 32'h0);
            set_in(6'h01);
            apb(1'b1, DIS_OFF_IRQ_ST, 32'h7);
            set_in(6'h09);
            chk_bit("fault", 1'b1, motor_fault);
            chk_bit("fault stop", 1'b0, run_cmd);
            chk_bit("irq masked", 1'b0, irq);
            apb(1'b1, DIS_OFF_IRQ_MASK, 32'(1 << DIS_IRQ_FAULT));
            @(posedge pclk);
            chk_bit("irq", 1'b1, irq);
            apb(1'b0, DIS_OFF_IRQ_ST, 32'h0);
            chk_val("irq status", 32'h1, q);
            set_in(6'h01);
            pulse(6'h10);
            chk_bit("fault clear", 1'b0, motor_fault);
            chk_bit("restart", j == 1, run_cmd);
            apb(1'b1, DIS_OFF_IRQ_ST, 32'h1);
            @(posedge pclk);
            chk_bit("irq clear", 1'b0, irq);
        end
        apb(1'b1, DIS_OFF_XF_SEL, 32'h0);
        apb(1'b1, DIS_OFF_SCHEME, 32'h1);
        set_in(6'h00);
        for (int j = 0; j < 3; j++) begin
            set_in(6'({6'h02, 6'h03, 6'h01} >> (6 * j)));
            chk_bit("dir run", j < 2, run_cmd);
            if (j < 2) chk_bit("dir sel", j == 1, reverse_dir);
        end
        apb(1'b1, DIS_OFF_SCHEME, 32'h2);
        set_in(6'h00);
        pulse(6'h01);
        chk_bit("pulse start", 1'b1, run_cmd);
        chk_bit("pulse fwd", 1'b0, reverse_dir);
        apb(1'b0, DIS_OFF_STATUS, 32'h0);
        chk_val("status", 32'h1, q);
        pulse(6'h02);
        chk_bit("pulse stop", 1'b0, run_cmd);
        pulse(6'h01);
        chk_bit("pulse restart", 1'b1, run_cmd);
        pulse(6'h03);
        chk_bit("stop wins", 1'b0, run_cmd);
        report_and_stop();
    end
endmodule
`default_nettype wire
